//--- rtl/ocob_pkg.sv
`default_nettype none
package ocob_pkg;
	// object indices
	localparam logic [15:0] IDX_DIG_CMD = 16'h6220;
	localparam logic [15:0] IDX_DIG_POL = 16'h6240;
	localparam logic [15:0] IDX_DIG_FRESP = 16'h6250;
	localparam logic [15:0] IDX_DIG_FLVL = 16'h6260;
	localparam logic [15:0] IDX_AN_CMD_DEC = 16'h6302;
	localparam logic [15:0] IDX_AN_KIND = 16'h6310;
	localparam logic [15:0] IDX_AN_LVL_DEC = 16'h6332;
	localparam logic [15:0] IDX_AN_FRESP = 16'h6340;
	localparam logic [15:0] IDX_AN_CMD = 16'h7300;
	localparam logic [15:0] IDX_AN_IN_LO = 16'h7320;
	localparam logic [15:0] IDX_AN_LVL_LO = 16'h7321;
	localparam logic [15:0] IDX_AN_IN_HI = 16'h7322;
	localparam logic [15:0] IDX_AN_LVL_HI = 16'h7323;
	localparam logic [15:0] IDX_AN_RESULT = 16'h7330;
	localparam logic [15:0] IDX_AN_FLVL = 16'h7341;
	localparam logic [15:0] IDX_LOOP_BAND = 16'h7450;
	localparam logic [15:0] IDX_LOOP_INT = 16'h7452;
	localparam logic [15:0] IDX_LOOP_DER = 16'h7454;
	localparam logic [15:0] IDX_LOOP_CYC = 16'h7456;
	localparam logic [15:0] IDX_LOOP_UNIT = 16'h7458;
	localparam logic [15:0] IDX_LOOP_DEC = 16'h7459;
	// sub-entries
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] ENTRY_COUNT = 8'h02;
	// reset values
	localparam logic RST_DIG_CMD = 1'b0;
	localparam logic [7:0] RST_DIG_POL = 8'h00;
	localparam logic [7:0] RST_DIG_FRESP = 8'h01;
	localparam logic RST_DIG_FLVL = 1'b1;
	localparam logic [7:0] RST_AN_CMD_DEC = 8'h03;
	localparam logic [7:0] MAX_AN_CMD_DEC = 8'h04;
	localparam logic [15:0] RST_AN_KIND = 16'h0014;
	localparam logic [15:0] RST_ZERO16 = 16'h0000;
	localparam logic [15:0] RST_SCALE_LO = 16'h012C;
	localparam logic [15:0] RST_SCALE_HI = 16'h05DC;
	localparam logic [7:0] RST_ZERO8 = 8'h00;
	// default timing unit, arbitrary value
	localparam logic [31:0] RST_LOOP_UNIT = 32'h0000_0001;
	// access answers
	localparam logic [1:0] ANS_OK = 2'h0;
	localparam logic [1:0] ANS_NO_OBJ = 2'h1;
	localparam logic [1:0] ANS_READ_ONLY = 2'h2;
	localparam logic [1:0] ANS_RANGE = 2'h3;
	typedef enum logic [1:0] {
		OCOB_IDLE = 2'b01,
		OCOB_ANSWER = 2'b10
	} ocob_state_t;
endpackage
`default_nettype wire

//--- rtl/ocob_bank.sv
// Notes on behaviour
// - Each digital output keeps a one-bit commanded state, off after reset, used when network-controlled.
// - The digital commanded state is written both by service access and by process data.
// - Each digital output has a polarity setting, zero by default meaning no inversion.
// - Each digital output has a fault response mode, one by default meaning apply the preset state.
// - Under fault with the mode enabled the digital output takes its stored fault state (on by default), inverted when polarity is set.
// - Each analog output holds a signed 16-bit commanded value, used only when network-controlled.
// - Each analog output stores its command decimals, 0 to 4 accepted, 3 by default.
// - Each analog output stores a 16-bit output kind, 20 (current) by default.
// - A read-only signed 16-bit resulting level per analog channel is readable and mapped.
// - The loop timing unit is a read-only 32-bit value and writes to it are refused.
// - The analog fault response mode is 8 bits, with a signed 16-bit level used under fault.
// - At or below the lower input point the analog output commands the lower scaling level.
`timescale 1ns/1ps
`default_nettype none
module ocob_bank
(
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// service access
	input wire logic svc_req,
	input wire logic svc_write,
	input wire logic [15:0] svc_index,
	input wire logic [7:0] svc_sub,
	input wire logic [31:0] svc_wdata,
	output logic svc_done,
	output logic [1:0] svc_status,
	output logic [31:0] svc_rdata,
	// process data in
	input wire logic pd_dig_valid,
	input wire logic [1:0] pd_dig_state,
	input wire logic pd_an_valid,
	input wire logic [31:0] pd_an_value,
	// application side
	input wire logic fault_in,
	input wire logic [1:0] dig_net_sel,
	input wire logic [1:0] an_net_sel,
	input wire logic [31:0] an_local_in,
	output logic [1:0] dig_drive,
	output logic [31:0] an_level
);
	import ocob_pkg::*;

	logic fault_s1;
	logic fault_s2;
	logic [1:0] dig_cmd;
	logic [7:0] dig_pol [2];
	logic [7:0] dig_fresp [2];
	logic [1:0] dig_flvl;
	logic [15:0] an_cmd [2];
	logic [7:0] an_cmd_dec [2];
	logic [15:0] an_kind [2];
	logic [7:0] an_lvl_dec [2];
	logic [7:0] an_fresp [2];
	logic [15:0] an_in_lo [2];
	logic [15:0] an_lvl_lo [2];
	logic [15:0] an_in_hi [2];
	logic [15:0] an_lvl_hi [2];
	logic [15:0] an_flvl [2];
	logic [15:0] loop_band [2];
	logic [15:0] loop_int [2];
	logic [15:0] loop_der [2];
	logic [15:0] loop_cyc [2];
	logic [7:0] loop_dec [2];
	logic [31:0] loop_unit [2];
	logic [15:0] an_result [2];
	ocob_state_t state;

	// decoded access
	logic known;
	logic ro_obj;
	logic chan_ok;
	logic ch;
	logic bad_range;
	logic wr_ok;
	logic [31:0] rd_val;

	function automatic logic [15:0] pick_level(input logic [15:0] src, input logic [15:0] in_lo,
			input logic [15:0] in_hi, input logic [15:0] lvl_lo, input logic [15:0] lvl_hi);
		if ($signed(src) <= $signed(in_lo))
			return lvl_lo;
		else if ($signed(src) >= $signed(in_hi))
			return lvl_hi;
		else
			return src;
	endfunction

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fault_s1 <= 1'b0;
			fault_s2 <= 1'b0;
		end else begin
			fault_s1 <= fault_in;
			fault_s2 <= fault_s1;
		end
	end

	always_comb begin
		known = 1'b1;
		ro_obj = 1'b0;
		ch = (svc_sub == 8'h02);
		chan_ok = (svc_sub == 8'h01) || (svc_sub == 8'h02);
		rd_val = 32'h0000_0000;
		bad_range = 1'b0;
		unique case (svc_index)
			IDX_DIG_CMD: rd_val = {31'h0, dig_cmd[ch]};
			IDX_DIG_POL: rd_val = {24'h0, dig_pol[ch]};
			IDX_DIG_FRESP: rd_val = {24'h0, dig_fresp[ch]};
			IDX_DIG_FLVL: rd_val = {31'h0, dig_flvl[ch]};
			IDX_AN_CMD_DEC: begin
				rd_val = {24'h0, an_cmd_dec[ch]};
				bad_range = svc_wdata[7:0] > MAX_AN_CMD_DEC;
			end
			IDX_AN_KIND: rd_val = {16'h0, an_kind[ch]};
			IDX_AN_LVL_DEC: rd_val = {24'h0, an_lvl_dec[ch]};
			IDX_AN_FRESP: rd_val = {24'h0, an_fresp[ch]};
			IDX_AN_CMD: rd_val = {{16{an_cmd[ch][15]}}, an_cmd[ch]};
			IDX_AN_IN_LO: rd_val = {{16{an_in_lo[ch][15]}}, an_in_lo[ch]};
			IDX_AN_LVL_LO: rd_val = {{16{an_lvl_lo[ch][15]}}, an_lvl_lo[ch]};
			IDX_AN_IN_HI: rd_val = {{16{an_in_hi[ch][15]}}, an_in_hi[ch]};
			IDX_AN_LVL_HI: rd_val = {{16{an_lvl_hi[ch][15]}}, an_lvl_hi[ch]};
			IDX_AN_RESULT: begin
				rd_val = {{16{an_result[ch][15]}}, an_result[ch]};
				ro_obj = 1'b1;
			end
			IDX_AN_FLVL: rd_val = {{16{an_flvl[ch][15]}}, an_flvl[ch]};
			IDX_LOOP_BAND: rd_val = {{16{loop_band[ch][15]}}, loop_band[ch]};
			IDX_LOOP_INT: rd_val = {{16{loop_int[ch][15]}}, loop_int[ch]};
			IDX_LOOP_DER: rd_val = {{16{loop_der[ch][15]}}, loop_der[ch]};
			IDX_LOOP_CYC: rd_val = {{16{loop_cyc[ch][15]}}, loop_cyc[ch]};
			IDX_LOOP_UNIT: begin
				rd_val = loop_unit[ch];
				ro_obj = 1'b1;
			end
			IDX_LOOP_DEC: rd_val = {24'h0, loop_dec[ch]};
			default: known = 1'b0;
		endcase
		if (svc_sub == SUB_COUNT) begin
			rd_val = {24'h0, ENTRY_COUNT};
			ro_obj = 1'b1;
		end else if (!chan_ok) begin
			known = 1'b0;
		end
		wr_ok = (state == OCOB_IDLE) && svc_req && svc_write && known && !ro_obj && !bad_range;
	end

	// service answer: one cycle after the request
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= OCOB_IDLE;
			svc_done <= 1'b0;
			svc_status <= ANS_OK;
			svc_rdata <= 32'h0000_0000;
		end else begin
			svc_done <= 1'b0;
			unique case (state)
				OCOB_IDLE: begin
					if (svc_req) begin
						state <= OCOB_ANSWER;
						svc_done <= 1'b1;
						svc_rdata <= svc_write ? 32'h0000_0000 : rd_val;
						if (!known)
							svc_status <= ANS_NO_OBJ;
						else if (svc_write && ro_obj)
							svc_status <= ANS_READ_ONLY;
						else if (svc_write && bad_range)
							svc_status <= ANS_RANGE;
						else
							svc_status <= ANS_OK;
					end
				end
				OCOB_ANSWER: state <= OCOB_IDLE;
				default: state <= OCOB_IDLE;
			endcase
		end
	end

	// digital command: process data wins over a same-cycle service write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dig_cmd <= {2{RST_DIG_CMD}};
		end else if (pd_dig_valid) begin
			dig_cmd <= pd_dig_state;
		end else if (wr_ok && svc_index == IDX_DIG_CMD) begin
			dig_cmd[ch] <= svc_wdata[0];
		end
	end

	// analog command: same ordering as digital
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			an_cmd[0] <= RST_ZERO16;
			an_cmd[1] <= RST_ZERO16;
		end else if (pd_an_valid) begin
			an_cmd[0] <= pd_an_value[15:0];
			an_cmd[1] <= pd_an_value[31:16];
		end else if (wr_ok && svc_index == IDX_AN_CMD) begin
			an_cmd[ch] <= svc_wdata[15:0];
		end
	end

	// configuration objects
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 2; i++) begin
				dig_pol[i] <= RST_DIG_POL;
				dig_fresp[i] <= RST_DIG_FRESP;
				dig_flvl[i] <= RST_DIG_FLVL;
				an_cmd_dec[i] <= RST_AN_CMD_DEC;
				an_kind[i] <= RST_AN_KIND;
				an_lvl_dec[i] <= RST_ZERO8;
				an_fresp[i] <= RST_ZERO8;
				an_in_lo[i] <= RST_SCALE_LO;
				an_lvl_lo[i] <= RST_SCALE_LO;
				an_in_hi[i] <= RST_SCALE_HI;
				an_lvl_hi[i] <= RST_SCALE_HI;
				an_flvl[i] <= RST_ZERO16;
				loop_band[i] <= RST_ZERO16;
				loop_int[i] <= RST_ZERO16;
				loop_der[i] <= RST_ZERO16;
				loop_cyc[i] <= RST_ZERO16;
				loop_dec[i] <= RST_ZERO8;
				loop_unit[i] <= RST_LOOP_UNIT;
			end
		end else if (wr_ok) begin
			unique case (svc_index)
				IDX_DIG_POL: dig_pol[ch] <= svc_wdata[7:0];
				IDX_DIG_FRESP: dig_fresp[ch] <= svc_wdata[7:0];
				IDX_DIG_FLVL: dig_flvl[ch] <= svc_wdata[0];
				IDX_AN_CMD_DEC: an_cmd_dec[ch] <= svc_wdata[7:0];
				IDX_AN_KIND: an_kind[ch] <= svc_wdata[15:0];
				IDX_AN_LVL_DEC: an_lvl_dec[ch] <= svc_wdata[7:0];
				IDX_AN_FRESP: an_fresp[ch] <= svc_wdata[7:0];
				IDX_AN_IN_LO: an_in_lo[ch] <= svc_wdata[15:0];
				IDX_AN_LVL_LO: an_lvl_lo[ch] <= svc_wdata[15:0];
				IDX_AN_IN_HI: an_in_hi[ch] <= svc_wdata[15:0];
				IDX_AN_LVL_HI: an_lvl_hi[ch] <= svc_wdata[15:0];
				IDX_AN_FLVL: an_flvl[ch] <= svc_wdata[15:0];
				IDX_LOOP_BAND: loop_band[ch] <= svc_wdata[15:0];
				IDX_LOOP_INT: loop_int[ch] <= svc_wdata[15:0];
				IDX_LOOP_DER: loop_der[ch] <= svc_wdata[15:0];
				IDX_LOOP_CYC: loop_cyc[ch] <= svc_wdata[15:0];
				IDX_LOOP_DEC: loop_dec[ch] <= svc_wdata[7:0];
				default: ;
			endcase
		end
	end

	// outputs; lower/upper ordering is the master's job
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (fault_s2 && an_fresp[i] != RST_ZERO8)
				an_result[i] = an_flvl[i];
			else
				an_result[i] = pick_level(an_net_sel[i] ? an_cmd[i] : an_local_in[16*i +: 16],
					an_in_lo[i], an_in_hi[i], an_lvl_lo[i], an_lvl_hi[i]);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dig_drive <= 2'b00;
			an_level <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (fault_s2 && dig_fresp[i] != RST_ZERO8)
					dig_drive[i] <= dig_flvl[i] ^ (dig_pol[i] != RST_DIG_POL);
				else
					dig_drive[i] <= (dig_net_sel[i] & dig_cmd[i]) ^ (dig_pol[i] != RST_DIG_POL);
			end
			an_level <= {an_result[1], an_result[0]};
		end
	end

	// rule checks: digital outputs
	AST_DIG_FAULT: assert property (@(posedge mclk) disable iff (!arst_n)
		(fault_s2 && dig_fresp[0] != RST_ZERO8) |=> dig_drive[0] == ($past(dig_flvl[0]) ^
		($past(dig_pol[0]) != RST_DIG_POL)))
		else $error("digital fault level not applied");
	AST_DIG_OFF: assert property (@(posedge mclk) disable iff (!arst_n)
		(!fault_s2 && !dig_net_sel[1] && dig_pol[1] == RST_DIG_POL) |=> !dig_drive[1])
		else $error("unselected output driven");
	AST_DIG_INVERT: assert property (@(posedge mclk) disable iff (!arst_n)
		(!fault_s2 && dig_net_sel[1] && dig_pol[1] != RST_DIG_POL)
		|=> dig_drive[1] == !$past(dig_cmd[1]))
		else $error("polarity not applied");
	AST_DIG_PD: assert property (@(posedge mclk) disable iff (!arst_n)
		pd_dig_valid |=> dig_cmd == $past(pd_dig_state))
		else $error("process data command not taken");

	// analog outputs
	AST_AN_PD: assert property (@(posedge mclk) disable iff (!arst_n)
		pd_an_valid |=> an_cmd[0] == $past(pd_an_value[15:0]) &&
		an_cmd[1] == $past(pd_an_value[31:16]))
		else $error("process data value not taken");
	AST_LOW_CLAMP: assert property (@(posedge mclk) disable iff (!arst_n)
		(!fault_s2 && an_net_sel[0] && $signed(an_cmd[0]) <= $signed(an_in_lo[0]))
		|=> an_level[15:0] == $past(an_lvl_lo[0]))
		else $error("lower scaling level not applied");
	AST_HIGH_CLAMP: assert property (@(posedge mclk) disable iff (!arst_n)
		(!fault_s2 && an_net_sel[1] && $signed(an_cmd[1]) > $signed(an_in_lo[1]) &&
		$signed(an_cmd[1]) >= $signed(an_in_hi[1]))
		|=> an_level[31:16] == $past(an_lvl_hi[1]))
		else $error("upper scaling level not applied");
	AST_AN_FAULT: assert property (@(posedge mclk) disable iff (!arst_n)
		(fault_s2 && an_fresp[0] != RST_ZERO8) |=> an_level[15:0] == $past(an_flvl[0]))
		else $error("analog fault level not applied");

	// service answers
	AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (!arst_n)
		svc_done |=> !svc_done)
		else $error("answer longer than one cycle");
	AST_RO_REFUSE: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == OCOB_IDLE && svc_req && svc_write && svc_index == IDX_LOOP_UNIT)
		|=> svc_done && svc_status != ANS_OK && $stable(loop_unit[0]))
		else $error("timing unit write not refused");
	AST_UNIT_FIXED: assert property (@(posedge mclk) disable iff (!arst_n)
		loop_unit[0] == RST_LOOP_UNIT && loop_unit[1] == RST_LOOP_UNIT)
		else $error("timing unit changed");
	AST_RESULT_RO: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == OCOB_IDLE && svc_req && svc_write && known &&
		svc_index == IDX_AN_RESULT) |=> svc_status == ANS_READ_ONLY)
		else $error("resulting level write not refused");
	AST_DEC_RANGE: assert property (@(posedge mclk) disable iff (!arst_n)
		an_cmd_dec[0] <= MAX_AN_CMD_DEC && an_cmd_dec[1] <= MAX_AN_CMD_DEC)
		else $error("decimals out of range");
	AST_DEC_REFUSE: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == OCOB_IDLE && svc_req && svc_write && svc_index == IDX_AN_CMD_DEC &&
		svc_sub == 8'h01 && svc_wdata[7:0] > MAX_AN_CMD_DEC)
		|=> svc_status == ANS_RANGE && $stable(an_cmd_dec[0]))
		else $error("decimals write not refused");
	AST_COUNT: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == OCOB_IDLE && svc_req && !svc_write && svc_sub == SUB_COUNT && known)
		|=> svc_rdata == {24'h00_0000, ENTRY_COUNT})
		else $error("entry count not two");
	AST_COUNT_RO: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == OCOB_IDLE && svc_req && svc_write && svc_sub == SUB_COUNT && known)
		|=> svc_status == ANS_READ_ONLY)
		else $error("entry count write not refused");
endmodule // ocob_bank
`default_nettype wire

//--- tb/ocob_master.sv
`timescale 1ns/1ps
`default_nettype none
module ocob_master (
	// clock
	input wire logic mclk,
	// service access
	output logic svc_req,
	output logic svc_write,
	output logic [15:0] svc_index,
	output logic [7:0] svc_sub,
	output logic [31:0] svc_wdata,
	input wire logic svc_done,
	input wire logic [1:0] svc_status,
	input wire logic [31:0] svc_rdata,
	// process data
	output logic pd_dig_valid,
	output logic [1:0] pd_dig_state,
	output logic pd_an_valid,
	output logic [31:0] pd_an_value
);
	initial begin
		svc_req = 1'b0;
		svc_write = 1'b0;
		svc_index = 16'h0000;
		svc_sub = 8'h00;
		svc_wdata = 32'h0000_0000;
		pd_dig_valid = 1'b0;
		pd_dig_state = 2'b00;
		pd_an_valid = 1'b0;
		pd_an_value = 32'h0000_0000;
	end
	task automatic svc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, output logic [1:0] st, output logic [31:0] rd, output bit ok);
		ok = 1'b0;
		svc_req <= 1'b1;
		svc_write <= wr;
		svc_index <= idx;
		svc_sub <= sub;
		svc_wdata <= wd;
		// request stays up until the answer is seen; the block ignores it meanwhile
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge mclk);
			ok = (svc_done === 1'b1);
		end
		st = svc_status;
		rd = svc_rdata;
		// released index and data lines show the inverse, not a stale value
		svc_req <= 1'b0;
		svc_index <= ~idx;
		svc_wdata <= ~wd;
		// one idle edge so a following call never re-raises the request in this step
		@(posedge mclk);
	endtask
	task automatic pd_dig(input logic [1:0] s);
		pd_dig_valid <= 1'b1;
		pd_dig_state <= s;
		@(posedge mclk);
		pd_dig_valid <= 1'b0;
		pd_dig_state <= ~s;
	endtask
	task automatic pd_an(input logic [31:0] v);
		pd_an_valid <= 1'b1;
		pd_an_value <= v;
		@(posedge mclk);
		pd_an_valid <= 1'b0;
		pd_an_value <= ~v;
	endtask
endmodule // ocob_master
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ocob_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic fault_in = 1'b0;
	logic [1:0] dig_net_sel = 2'b00;
	logic [1:0] an_net_sel = 2'b00;
	logic [31:0] an_local_in = 32'h0000_0000;
	logic svc_req, svc_write, svc_done, pd_dig_valid, pd_an_valid;
	logic [15:0] svc_index;
	logic [7:0] svc_sub;
	logic [31:0] svc_wdata, svc_rdata, pd_an_value, an_level;
	logic [1:0] svc_status, pd_dig_state, dig_drive;
	logic [1:0] st;
	logic [31:0] rd;
	int miscompares = 0;
	int samples_checked = 0;
	always #20 mclk = ~mclk;
	ocob_bank dut (.mclk, .arst_n, .svc_req, .svc_write, .svc_index, .svc_sub, .svc_wdata,
		.svc_done, .svc_status, .svc_rdata, .pd_dig_valid, .pd_dig_state, .pd_an_valid,
		.pd_an_value, .fault_in, .dig_net_sel, .an_net_sel, .an_local_in, .dig_drive, .an_level);
	ocob_master m (.mclk, .svc_req, .svc_write, .svc_index, .svc_sub, .svc_wdata, .svc_done,
		.svc_status, .svc_rdata, .pd_dig_valid, .pd_dig_state, .pd_an_valid, .pd_an_value);
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd);
		bit ok;
		m.svc(wr, idx, sub, wd, st, rd, ok);
		if (!ok) begin
			miscompares++;
			$display("MISMATCH svc_done expected 1 seen 0");
			wrap_up();
		end
	endtask
	task automatic rchk(input string what, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] exp);
		acc(1'b0, idx, sub, 32'h0000_0000);
		check(what, rd, exp);
	endtask
	task automatic wchk(input string what, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic [1:0] exp);
		acc(1'b1, idx, sub, wd);
		check(what, {30'h0, st}, {30'h0, exp});
	endtask
	task automatic t_defaults();
		rchk("dig_cmd", IDX_DIG_CMD, 8'h01, {31'h0, RST_DIG_CMD});
		rchk("dig_pol", IDX_DIG_POL, 8'h02, {24'h0, RST_DIG_POL});
		rchk("dig_fresp", IDX_DIG_FRESP, 8'h01, {24'h0, RST_DIG_FRESP});
		rchk("dig_flvl", IDX_DIG_FLVL, 8'h02, {31'h0, RST_DIG_FLVL});
		rchk("an_dec", IDX_AN_CMD_DEC, 8'h01, {24'h0, RST_AN_CMD_DEC});
		rchk("an_kind", IDX_AN_KIND, 8'h02, {16'h0, RST_AN_KIND});
		rchk("count", IDX_AN_KIND, SUB_COUNT, {24'h0, ENTRY_COUNT});
		check("an_level", an_level, {RST_SCALE_LO, RST_SCALE_LO});
	endtask
	task automatic t_digital();
		dig_net_sel <= 2'b11;
		wchk("wr cmd", IDX_DIG_CMD, 8'h01, 32'h0000_0001, ANS_OK);
		cyc(3);
		check("drive svc", {30'h0, dig_drive}, 32'h0000_0001);
		m.pd_dig(2'b10);
		cyc(3);
		check("drive pd", {30'h0, dig_drive}, 32'h0000_0002);
		rchk("cmd pd", IDX_DIG_CMD, 8'h02, 32'h0000_0001);
		wchk("pol", IDX_DIG_POL, 8'h02, 32'h0000_0001, ANS_OK);
		cyc(3);
		check("drive inv", {30'h0, dig_drive}, 32'h0000_0000);
	endtask
	task automatic t_fault();
		wchk("an fresp", IDX_AN_FRESP, 8'h01, 32'h0000_0001, ANS_OK);
		wchk("an flvl", IDX_AN_FLVL, 8'h01, 32'h0000_FF9C, ANS_OK);
		fault_in <= 1'b1;
		cyc(5);
		check("drive flt", {30'h0, dig_drive}, 32'h0000_0001);
		check("an flt", {16'h0, an_level[15:0]}, 32'h0000_FF9C);
		wchk("flvl", IDX_DIG_FLVL, 8'h02, 32'h0000_0000, ANS_OK);
		cyc(3);
		check("drive lvl", {30'h0, dig_drive}, 32'h0000_0003);
		wchk("fresp", IDX_DIG_FRESP, 8'h02, 32'h0000_0000, ANS_OK);
		cyc(3);
		check("drive off", {30'h0, dig_drive}, 32'h0000_0001);
		fault_in <= 1'b0;
		cyc(5);
		check("an clr", {16'h0, an_level[15:0]}, {16'h0, RST_SCALE_LO});
	endtask
	task automatic t_analog();
		an_local_in <= 32'h0000_03E8;
		an_net_sel <= 2'b10;
		wchk("in hi", IDX_AN_IN_HI, 8'h02, 32'h0000_02BC, ANS_OK);
		m.pd_an(32'h0320_FFFB);
		cyc(3);
		check("an sel", an_level, {RST_SCALE_HI, 16'h03E8});
		an_net_sel <= 2'b11;
		cyc(3);
		check("an low", {16'h0, an_level[15:0]}, {16'h0, RST_SCALE_LO});
		rchk("an cmd", IDX_AN_CMD, 8'h01, 32'hFFFF_FFFB);
		rchk("an result", IDX_AN_RESULT, 8'h02, {16'h0, RST_SCALE_HI});
	endtask
	task automatic t_refuse();
		wchk("unit wr", IDX_LOOP_UNIT, 8'h01, 32'h0000_0055, ANS_READ_ONLY);
		rchk("unit", IDX_LOOP_UNIT, 8'h01, RST_LOOP_UNIT);
		wchk("result wr", IDX_AN_RESULT, 8'h01, 32'h0000_0001, ANS_READ_ONLY);
		wchk("dec 5", IDX_AN_CMD_DEC, 8'h01, 32'h0000_0005, ANS_RANGE);
		rchk("dec kept", IDX_AN_CMD_DEC, 8'h01, {24'h0, RST_AN_CMD_DEC});
		wchk("dec 4", IDX_AN_CMD_DEC, 8'h01, {24'h0, MAX_AN_CMD_DEC}, ANS_OK);
		rchk("dec new", IDX_AN_CMD_DEC, 8'h01, {24'h0, MAX_AN_CMD_DEC});
		wchk("count wr", IDX_DIG_CMD, SUB_COUNT, 32'h0000_0001, ANS_READ_ONLY);
		wchk("no obj", 16'h1234, 8'h01, 32'h0000_0001, ANS_NO_OBJ);
		wchk("fresp8", IDX_AN_FRESP, 8'h02, 32'h0000_01FF, ANS_OK);
		rchk("fresp8 rd", IDX_AN_FRESP, 8'h02, 32'h0000_00FF);
	endtask
	initial begin
		cyc(16);
		arst_n <= 1'b1;
		cyc(2);
		t_defaults();
		$display("defaults test done");
		t_digital();
		$display("digital test done");
		t_fault();
		$display("fault test done");
		t_analog();
		$display("analog test done");
		t_refuse();
		$display("refusal test done");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
